/* File: iebk_enable_bank.sv */
// interrupt enable bank: four 16-bit enable words behind an axi4-lite slave,
// gating flag bits into per-source requests for the core's interrupt logic.
// assumes flags and priorities come from logic on aclk (no synchroniser).
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// What this block does
// - an enable bit of 1 passes its source's request, 0 blocks it
// - implemented enable bits reset to 0 and are software readable and writable
// - unimplemented enable bits ignore writes and read as zero
// - word 1 bit 15 gates uart2 transmit, bit 14 uart2 receive
// - word 1 bit 13 gates external interrupt 2, bit 4 external interrupt 1
// - word 1 bit 12 gates timer 5, bit 11 timer 4
// - word 1 bits 10 and 9 gate compare channels 4 and 3; bit 8 absent
// - word 1 bits 7 and 6 gate capture channels 8 and 7; bit 5 absent
// - word 1 bit 3 gates change notification, bit 2 the comparator
// - word 1 bit 1 gates i2c1 master event, bit 0 i2c1 slave event
// - word 2 bit 13 gates the parallel port; bits 15 and 14 absent
// - word 2 bits 12 to 9 gate compare channels 8 to 5
// - word 2 bits 8 to 5 gate capture channels 6 to 3; bits 4-2 absent
// - word 2 bit 1 gates spi2 event, bit 0 spi2 fault
// - word 3 bit 14 gates the rtc; bits 15 and 13-7 absent
// - word 3 bits 6 and 5 gate external interrupts 4 and 3; bits 4-3 absent
// - word 3 bits 2 and 1 gate i2c2 master and slave; bit 0 absent
// - word 4 bit 13 gates charge-time unit, bit 8 low voltage; bits 12-9 absent
// - word 4 bit 3 gates the crc generator; bits 7-4 absent
// - word 4 bits 2 and 1 gate uart2 and uart1 errors; bit 0 absent
// - each source's flag records a request; its enable decides forwarding
// - a priority of 000 disables a source; 111 is highest
module iebk_enable_bank
  import iebk_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire iebk_bank_t irq_flag,
  input wire iebk_prio_t irq_prio,
  output iebk_bank_t irq_enable,
  output iebk_bank_t irq_request
);

  // ****************************************************************
  // address decode helpers
  // ****************************************************************

  // word index of a byte address; low two bits are ignored
  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_LSB +: IDX_W];
  endfunction

  // address falls inside the eight-word window
  function automatic logic in_window(input logic [ADDR_W-1:0] a);
    in_window = (a >> (ADDR_LSB + IDX_W)) == '0;
  endfunction

  // ****************************************************************
  // implemented-bit masks
  // ****************************************************************
  iebk_words_t impl_mask;

  // every bit not set here is unimplemented: it never stores and reads zero
  always_comb begin
    impl_mask = '0;
    impl_mask[0][E1_UART2_TX] = 1'b1;
    impl_mask[0][E1_UART2_RX] = 1'b1;
    impl_mask[0][E1_EXT2] = 1'b1;
    impl_mask[0][E1_EXT1] = 1'b1;
    impl_mask[0][E1_TIMER5] = 1'b1;
    impl_mask[0][E1_TIMER4] = 1'b1;
    impl_mask[0][E1_CMP4] = 1'b1;
    impl_mask[0][E1_CMP3] = 1'b1;
    impl_mask[0][E1_CAP8] = 1'b1;
    impl_mask[0][E1_CAP7] = 1'b1;
    impl_mask[0][E1_CHANGE] = 1'b1;
    impl_mask[0][E1_COMPARATOR] = 1'b1;
    impl_mask[0][E1_I2C1_MST] = 1'b1;
    impl_mask[0][E1_I2C1_SLV] = 1'b1;
    impl_mask[1][E2_PARPORT] = 1'b1;
    for (int b = E2_CMP5; b <= E2_CMP8; b++) begin
      impl_mask[1][b] = 1'b1;
    end
    for (int b = E2_CAP3; b <= E2_CAP6; b++) begin
      impl_mask[1][b] = 1'b1;
    end
    impl_mask[1][E2_SPI2_EVT] = 1'b1;
    impl_mask[1][E2_SPI2_FLT] = 1'b1;
    impl_mask[2][E3_RTC] = 1'b1;
    impl_mask[2][E3_EXT4] = 1'b1;
    impl_mask[2][E3_EXT3] = 1'b1;
    impl_mask[2][E3_I2C2_MST] = 1'b1;
    impl_mask[2][E3_I2C2_SLV] = 1'b1;
    impl_mask[3][E4_CHARGE_TIME] = 1'b1;
    impl_mask[3][E4_LOW_VOLT] = 1'b1;
    impl_mask[3][E4_CRC] = 1'b1;
    impl_mask[3][E4_UART2_ERR] = 1'b1;
    impl_mask[3][E4_UART1_ERR] = 1'b1;
  end

  // ****************************************************************
  // state
  // ****************************************************************
  iebk_words_t en_reg;
  iebk_words_t en_next;
  iebk_words_t req_reg;
  iebk_words_t req_next;
  iebk_words_t flag_w;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [WORD_W-1:0] wdata_reg;
  logic [1:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [WORD_W-1:0] rdata_reg;

  // ****************************************************************
  // request gating
  // ****************************************************************

  // flag struct to word array so one loop serves all four words
  assign flag_w = {irq_flag.w4, irq_flag.w3, irq_flag.w2, irq_flag.w1};

  // the flag holds the occurrence; the enable and priority decide forwarding.
  // registered so the core sees a clean level, at the cost of one cycle.
  always_comb begin
    for (int r = 0; r < NUM_WORDS; r++) begin
      for (int b = 0; b < WORD_W; b++) begin
        req_next[r][b] = flag_w[r][b]
          & en_reg[r][b]
          & (irq_prio[r][b] != PRIO_OFF);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end

  // ****************************************************************
  // write channel
  // ****************************************************************
  logic aw_take;
  logic w_take;
  logic do_wr;
  logic b_done;
  logic [IDX_W-1:0] wr_idx;
  logic wr_hit;
  logic wr_en_word;
  logic [WORD_W-1:0] wr_lane_mask;

  assign aw_take = s_axi_awvalid & awready_reg;
  assign w_take = s_axi_wvalid & wready_reg;
  // both halves held and no response pending: commit the write
  assign do_wr = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign b_done = bvalid_reg & s_axi_bready;
  assign wr_idx = word_idx(waddr_reg);
  assign wr_hit = in_window(waddr_reg);
  assign wr_en_word = wr_hit & (wr_idx < IDX_REQ1);
  // only byte lanes 0 and 1 carry enable bits; upper lanes are dropped
  assign wr_lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  // address and data accepted in either order, each held until the commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end else if (do_wr) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[WORD_W-1:0];
        wstrb_reg <= s_axi_wstrb[1:0];
        wready_reg <= 1'b0;
      end else if (do_wr) begin
        w_hold_reg <= 1'b0;
      end
      // channels reopen only once the response is taken: one write at a time
      if (b_done) begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // write response: unmapped decodes, read-only request words are refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      if (!wr_hit) begin
        bresp_reg <= RESP_DECERR;
      end else if (!wr_en_word) begin
        bresp_reg <= RESP_SLVERR;
      end else begin
        bresp_reg <= RESP_OKAY;
      end
    end else if (b_done) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // enable registers
  // ****************************************************************

  // merge written lanes into the addressed word, implemented bits only
  always_comb begin
    en_next = en_reg;
    for (int r = 0; r < NUM_WORDS; r++) begin
      if (do_wr && wr_en_word && (wr_idx == IDX_EN1 + IDX_W'(r))) begin
        en_next[r] = (en_reg[r] & ~(wr_lane_mask & impl_mask[r]))
          | (wdata_reg & wr_lane_mask & impl_mask[r]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < NUM_WORDS; r++) begin
        en_reg[r] <= EN_RESET;
      end
    end else begin
      en_reg <= en_next;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic ar_take;
  logic r_done;
  logic [IDX_W-1:0] rd_idx;
  logic rd_hit;
  logic [WORD_W-1:0] rd_word;

  assign ar_take = s_axi_arvalid & arready_reg;
  assign r_done = rvalid_reg & s_axi_rready;
  assign rd_idx = word_idx(s_axi_araddr);
  assign rd_hit = in_window(s_axi_araddr);
  // lower half of the window is the enables, upper half the gated requests
  assign rd_word = (rd_idx < IDX_REQ1) ? en_reg[rd_idx[1:0]] & impl_mask[rd_idx[1:0]]
    : req_reg[rd_idx[1:0]];

  // one read at a time; data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_DECERR;
      rdata_reg <= rd_hit ? rd_word : '0;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs, all straight from flip-flops
  // ****************************************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  // upper half of the data word always reads zero
  assign s_axi_rdata = {{(AXI_DATA_W - WORD_W){1'b0}}, rdata_reg};
  assign irq_enable.w1 = en_reg[0];
  assign irq_enable.w2 = en_reg[1];
  assign irq_enable.w3 = en_reg[2];
  assign irq_enable.w4 = en_reg[3];
  // external sources still need pin routing elsewhere before they fire
  assign irq_request.w1 = req_reg[0];
  assign irq_request.w2 = req_reg[1];
  assign irq_request.w3 = req_reg[2];
  assign irq_request.w4 = req_reg[3];

endmodule

/* File: iebk_pkg.sv */
// package for the interrupt enable bank: register map, bit positions, carriers.
// assumes a 32-bit axi4-lite slave port and four 16-bit enable words.
package iebk_pkg;

  // ****************************************************************
  // sizes and register map
  // ****************************************************************
  localparam int NUM_WORDS = 4;
  localparam int WORD_W = 16;
  localparam int PRIO_W = 3;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = 4;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 3;
  // enable words 1..4 at 0x00..0x0c, gated request words 1..4 at 0x10..0x1c
  localparam logic [2:0] IDX_EN1 = 3'h0;
  localparam logic [2:0] IDX_REQ1 = 3'h4;
  localparam logic [WORD_W-1:0] EN_RESET = 16'h0000;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************************************
  // enable bit positions, word 1
  // ****************************************************************
  localparam int E1_UART2_TX = 15;
  localparam int E1_UART2_RX = 14;
  localparam int E1_EXT2 = 13;
  localparam int E1_TIMER5 = 12;
  localparam int E1_TIMER4 = 11;
  localparam int E1_CMP4 = 10;
  localparam int E1_CMP3 = 9;
  localparam int E1_CAP8 = 7;
  localparam int E1_CAP7 = 6;
  localparam int E1_EXT1 = 4;
  localparam int E1_CHANGE = 3;
  localparam int E1_COMPARATOR = 2;
  localparam int E1_I2C1_MST = 1;
  localparam int E1_I2C1_SLV = 0;
  // word 2
  localparam int E2_PARPORT = 13;
  localparam int E2_CMP8 = 12;
  localparam int E2_CMP5 = 9;
  localparam int E2_CAP6 = 8;
  localparam int E2_CAP3 = 5;
  localparam int E2_SPI2_EVT = 1;
  localparam int E2_SPI2_FLT = 0;
  // word 3
  localparam int E3_RTC = 14;
  localparam int E3_EXT4 = 6;
  localparam int E3_EXT3 = 5;
  localparam int E3_I2C2_MST = 2;
  localparam int E3_I2C2_SLV = 1;
  // word 4
  localparam int E4_CHARGE_TIME = 13;
  localparam int E4_LOW_VOLT = 8;
  localparam int E4_CRC = 3;
  localparam int E4_UART2_ERR = 2;
  localparam int E4_UART1_ERR = 1;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [WORD_W-1:0] w4;
    logic [WORD_W-1:0] w3;
    logic [WORD_W-1:0] w2;
    logic [WORD_W-1:0] w1;
  } iebk_bank_t;

  typedef logic [NUM_WORDS-1:0][WORD_W-1:0][PRIO_W-1:0] iebk_prio_t;
  typedef logic [NUM_WORDS-1:0][WORD_W-1:0] iebk_words_t;

endpackage

/* File: iebk_monitor.sv */
// assertion checker for the interrupt enable bank, watching its ports only.
// assumes one clock, aclk, and the synchronous active-low reset aresetn.
`timescale 1ns/100ps
// ****************
// port checker
// ****************
module iebk_monitor
  import iebk_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire iebk_bank_t irq_flag,
  input wire iebk_prio_t irq_prio,
  input wire iebk_bank_t irq_enable,
  input wire iebk_bank_t irq_request
);
  localparam logic [63:0] IMPL = 64'h210e_4066_3fe3_fedf;
  logic [63:0] live;
  // a zero priority silences a source whatever its enable says
  always_comb begin
    for (int w = 0; w < NUM_WORDS; w++) begin
      for (int b = 0; b < WORD_W; b++) begin
        live[w * WORD_W + b] = irq_prio[w][b] != PRIO_OFF;
      end
    end
  end
  // what the request word should become at the next edge
  logic [63:0] gate_now;
  assign gate_now = irq_flag & irq_enable & live;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_req_gated: assert property (irq_request == $past(gate_now))
    else $error("request not flag and enable and priority");
  a_unimpl_zero: assert property (((irq_enable | irq_request) & ~IMPL) == 64'h0)
    else $error("absent bit set");
  a_en_commit: assert property (!$stable(irq_enable) |-> $rose(s_axi_bvalid))
    else $error("enable changed without a write");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during response");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && !s_axi_arready)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && s_axi_rdata[31:16] == 16'h0)
    else $error("read data unstable");
  a_en_reset: assert property ($rose(aresetn) |-> irq_enable == 64'h0
      && irq_request == 64'h0 && !s_axi_bvalid)
    else $error("not cleared by reset");
endmodule
bind iebk_enable_bank iebk_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_flag, .irq_prio,
  .irq_enable, .irq_request);

/* File: iebk_src_model.sv */
// source-side model: flag levels and priority fields seen by the bank.
// assumes new values are asked for just after a rising edge of aclk.
`timescale 1ns/100ps
// ****************
// flag and priority holder
// ****************
module iebk_src_model
  import iebk_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [63:0] flag_in,
  input wire logic [2:0] prio_in,
  output iebk_bank_t irq_flag,
  output iebk_prio_t irq_prio
);
  // every external source counts as routed to a pin, so its flag arrives
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag <= '0;
      irq_prio <= '0;
    end else if (load) begin
      irq_flag <= flag_in;
      irq_prio <= {(NUM_WORDS * WORD_W){prio_in}};
    end
  end
endmodule

/* File: interrupt_enable_bank_1_to_4_test.sv */
// self-checking bench for the interrupt enable bank over axi4-lite.
// assumes enables at 0x00..0x0c and gated request words at 0x10..0x1c.
`timescale 1ns/100ps
module interrupt_enable_bank_1_to_4_test
  import iebk_pkg::*;
;
  localparam logic [15:0] MSK [4] = '{16'hfedf, 16'h3fe3, 16'h4066, 16'h210e};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic load = 1'b0;
  logic [2:0] prio_in = 3'h0;
  logic [63:0] flag_in = 64'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  iebk_bank_t irq_flag;
  iebk_prio_t irq_prio;
  iebk_bank_t irq_enable;
  iebk_bank_t irq_request;
  logic [15:0] en_m [4];
  logic [15:0] req_e [4];
  logic [127:0] lq [$];
  logic lv_chk = 1'b0;
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  int error_cnt = 0;
  int tests_run = 0;

  always #10 aclk = ~aclk;

  iebk_enable_bank dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_flag, .irq_prio, .irq_enable,
    .irq_request);
  iebk_src_model src_u (.aclk, .aresetn, .load, .flag_in, .prio_in, .irq_flag, .irq_prio);

  // ****************
  // compares and closing
  // ****************
  task automatic cmp_r(input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_b(input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_w(input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // results are matched against the oldest note as each handshake lands
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      cmp_r(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    if (s_axi_bvalid && s_axi_bready) begin
      cmp_b(bq.pop_front(), s_axi_bresp);
    end
    // enable and request levels, looked at while the bench holds them still
    if (lv_chk) begin
      cmp_w(lq.pop_front(), {irq_enable, irq_request});
    end
  end

  // ****************
  // bus master
  // ****************
  // the answer is stalled a random while to exercise the hold side
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    fork
      begin
        s_axi_awvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // strobed lanes replace their byte, absent bits never stick
  task automatic wen(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] lm;
    lm = {{8{s[1]}}, {8{s[0]}}};
    en_m[i] = ((en_m[i] & ~lm) | (d[15:0] & lm)) & MSK[i];
    wr(8'(4 * i), d, s, RESP_OKAY);
  endtask
  task automatic ren(input int i);
    rd(8'(4 * i), {RESP_OKAY, 16'h0, en_m[i]});
  endtask
  // note the expected output levels and flag one edge for the watcher
  task automatic chk_lv();
    lq.push_back({en_m[3], en_m[2], en_m[1], en_m[0], req_e[3], req_e[2], req_e[1], req_e[0]});
    lv_chk <= 1'b1;
    @(posedge aclk);
    lv_chk <= 1'b0;
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (en_m[i]) en_m[i] = EN_RESET;
    foreach (req_e[i]) req_e[i] = 16'h0;
  endtask

  // ****************
  // scenarios
  // ****************
  initial begin
    void'($urandom(9620));
    do_reset();
    for (int i = 0; i < 4; i++) begin
      ren(i);
      rd(8'(16 + 4 * i), {RESP_OKAY, 32'h0});
    end
    for (int i = 0; i < 4; i++) begin
      wen(i, 32'hffff_ffff, 4'hf);
      ren(i);
    end
    chk_lv();
    repeat (24) begin
      wen(int'($urandom_range(3)), $urandom, 4'($urandom));
      ren(int'($urandom_range(3)));
    end
    // every priority code against random flags and the current enables
    for (int p = 0; p < 8; p++) begin
      flag_in <= {$urandom, $urandom};
      prio_in <= 3'(p);
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
        req_e[i] = (p == 0) ? 16'h0 : flag_in[16 * i +: 16] & en_m[i];
        rd(8'(16 + 4 * i), {RESP_OKAY, 16'h0, req_e[i]});
      end
      chk_lv();
    end
    wr(8'h10, 32'hffff, 4'hf, RESP_SLVERR);
    wr(8'h20, 32'hffff, 4'hf, RESP_DECERR);
    rd(8'h24, {RESP_DECERR, 32'h0});
    ren(0);
    do_reset();
    for (int i = 0; i < 4; i++) begin
      ren(i);
    end
    chk_lv();
    wrap_up();
  end
  // hang guard, far beyond the hundred or so transfers above
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    wrap_up();
  end
endmodule
